// ===== wtsr_top.sv
// window trigger with segmented recording into acquisition memory
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "wtsr_consts.svh"

module wtsr_top
  import wtsr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire wtsr_reg_req_t i_req,
  input wire logic [7:0] i_sample,
  output logic [31:0] o_rdata,
  output wtsr_mem_wr_t o_mem,
  output logic o_trig,
  output logic o_seg_done,
  output logic o_busy
);

  // ==========================================================================
  // register file
  logic [31:0] total_count_q;
  logic [31:0] seg_len_q;
  logic [31:0] trig_src_q;
  logic [31:0] ch_mode_q;
  logic [31:0] upper_q;
  logic [31:0] lower_q;
  logic [31:0] pulse_len_q;
  logic [31:0] seg_enable_q;
  logic fifo_q;
  logic start_cmd;
  logic stop_cmd;
  logic [31:0] seg_done_cnt_q;
  wtsr_state_t state_q;

  // address match shared by the write and read paths
  function automatic logic hit(input logic [17:0] a, input logic [17:0] ref_addr);
    hit = (a == ref_addr);
  endfunction : hit

  // software writes; control bits 0 and 1 are commands and are not stored
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      total_count_q <= `WTSR_RST_WORD;
      seg_len_q <= `WTSR_RST_WORD;
      trig_src_q <= `WTSR_RST_WORD;
      ch_mode_q <= `WTSR_RST_WORD;
      upper_q <= `WTSR_RST_WORD;
      lower_q <= `WTSR_RST_WORD;
      pulse_len_q <= `WTSR_RST_PULSE;
      seg_enable_q <= `WTSR_RST_WORD;
      fifo_q <= 1'b0;
    end
    else if (i_req.wr)
    begin
      if (hit(i_req.addr, `WTSR_ADDR_TOTAL_COUNT))
        total_count_q <= i_req.wdata;
      else if (hit(i_req.addr, `WTSR_ADDR_SEG_LEN))
        seg_len_q <= i_req.wdata;
      else if (hit(i_req.addr, `WTSR_ADDR_TRIG_SRC))
        trig_src_q <= i_req.wdata;
      else if (hit(i_req.addr, `WTSR_ADDR_CH_MODE))
        ch_mode_q <= i_req.wdata;
      else if (hit(i_req.addr, `WTSR_ADDR_UPPER))
        upper_q <= i_req.wdata;
      else if (hit(i_req.addr, `WTSR_ADDR_LOWER))
        lower_q <= i_req.wdata;
      else if (hit(i_req.addr, `WTSR_ADDR_PULSE_LEN))
        pulse_len_q <= i_req.wdata;
      else if (hit(i_req.addr, `WTSR_ADDR_SEG_ENABLE))
        seg_enable_q <= i_req.wdata;
      else if (hit(i_req.addr, `WTSR_ADDR_CONTROL))
        fifo_q <= i_req.wdata[`WTSR_CTL_FIFO];
    end
  end

  // command strobes taken straight from the write beat
  assign start_cmd = i_req.wr && hit(i_req.addr, `WTSR_ADDR_CONTROL)
                     && i_req.wdata[`WTSR_CTL_START];
  assign stop_cmd = i_req.wr && hit(i_req.addr, `WTSR_ADDR_CONTROL)
                    && i_req.wdata[`WTSR_CTL_STOP];

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= 32'h00000000;
    else if (!i_req.rd)
      o_rdata <= 32'h00000000;
    else if (hit(i_req.addr, `WTSR_ADDR_TOTAL_COUNT))
      o_rdata <= total_count_q;
    else if (hit(i_req.addr, `WTSR_ADDR_SEG_LEN))
      o_rdata <= seg_len_q;
    else if (hit(i_req.addr, `WTSR_ADDR_TRIG_SRC))
      o_rdata <= trig_src_q;
    else if (hit(i_req.addr, `WTSR_ADDR_CH_MODE))
      o_rdata <= ch_mode_q;
    else if (hit(i_req.addr, `WTSR_ADDR_UPPER))
      o_rdata <= upper_q;
    else if (hit(i_req.addr, `WTSR_ADDR_LOWER))
      o_rdata <= lower_q;
    else if (hit(i_req.addr, `WTSR_ADDR_PULSE_LEN))
      o_rdata <= pulse_len_q;
    else if (hit(i_req.addr, `WTSR_ADDR_SEG_ENABLE))
      o_rdata <= seg_enable_q;
    else if (hit(i_req.addr, `WTSR_ADDR_CONTROL))
      o_rdata <= {29'h00000000, fifo_q, 2'b00};
    else if (hit(i_req.addr, `WTSR_ADDR_STATUS))
      o_rdata <= {29'h00000000, state_q == WTSR_DONE, state_q == WTSR_RECORD,
                  state_q == WTSR_ARMED};
    else if (hit(i_req.addr, `WTSR_ADDR_SEG_DONE_CNT))
      o_rdata <= seg_done_cnt_q;
    else
      o_rdata <= 32'h00000000;
  end

  // ==========================================================================
  // window comparison and pulse qualifier
  logic in_win;
  logic prev_in_q;
  logic entry;
  logic exit_win;
  logic [7:0] pulse_len;
  logic [7:0] cnt_q;
  logic run_q;
  logic expire;
  logic out_mode;
  logic qual_mode;
  logic trig;
  logic src_ok;

  // levels use the low byte, matching the 8-bit sample range
  assign in_win = (i_sample >= lower_q[7:0]) && (i_sample <= upper_q[7:0]);
  assign entry = in_win && !prev_in_q;
  assign exit_win = !in_win && prev_in_q;

  // out-of-range lengths are clamped so the counter can never hang at zero
  assign pulse_len = (pulse_len_q[31:8] != 24'h000000) ? `WTSR_PULSE_MAX
                     : (pulse_len_q[7:0] < `WTSR_PULSE_MIN) ? `WTSR_PULSE_MIN
                     : pulse_len_q[7:0];
  assign expire = run_q && (cnt_q == 8'h01);
  assign out_mode = (ch_mode_q == `WTSR_MODE_LONG_OUTSIDE)
                    || (ch_mode_q == `WTSR_MODE_SHORT_OUTSIDE);
  assign qual_mode = out_mode || (ch_mode_q == `WTSR_MODE_LONG_INSIDE)
                     || (ch_mode_q == `WTSR_MODE_SHORT_INSIDE);
  assign src_ok = (trig_src_q == `WTSR_SRC_ANALOG_CHANNEL);

  // previous inside status, updated on every sample
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      prev_in_q <= 1'b0;
    else
      prev_in_q <= in_win;
  end

  // counter starts on exit in outside modes, on entry in inside modes
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
    end
    else if (!qual_mode)
    begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
    end
    else if (out_mode ? exit_win : entry)
    begin
      run_q <= 1'b1;
      cnt_q <= pulse_len - 8'h01;
    end
    else if (run_q && (expire || (out_mode ? entry : exit_win)))
      run_q <= 1'b0;
    else if (run_q)
      cnt_q <= cnt_q - 8'h01;
  end

  // trigger decision per mode
  always_comb
  begin
    trig = 1'b0;
    case (ch_mode_q)
      `WTSR_MODE_ENTER: trig = entry;
      `WTSR_MODE_LEAVE: trig = exit_win;
      `WTSR_MODE_LONG_INSIDE: trig = expire && in_win;
      `WTSR_MODE_SHORT_INSIDE: trig = run_q && exit_win;
      `WTSR_MODE_LONG_OUTSIDE: trig = expire && !in_win;
      `WTSR_MODE_SHORT_OUTSIDE: trig = run_q && entry;
      default: trig = 1'b0;
    endcase
    trig = trig && src_ok;
  end

  // ==========================================================================
  // acquisition sequencer
  logic seg_mode;
  logic [31:0] rec_len;
  logic [31:0] seg_cnt_q;
  logic [31:0] total_q;
  logic [31:0] addr_q;
  logic seg_last;
  logic total_last;

  assign seg_mode = seg_enable_q[0];
  // single-trigger acquisition records the whole total count
  assign rec_len = seg_mode ? seg_len_q : total_count_q;
  assign seg_last = (seg_cnt_q + 32'h00000001 >= rec_len);
  assign total_last = (total_q + 32'h00000001 >= total_count_q);

  // state and counters; the trigger sample itself is not stored
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= WTSR_IDLE;
      seg_cnt_q <= 32'h00000000;
      total_q <= 32'h00000000;
      addr_q <= 32'h00000000;
      seg_done_cnt_q <= 32'h00000000;
    end
    else
    begin
      case (state_q)
        WTSR_IDLE, WTSR_DONE:
          if (start_cmd)
          begin
            state_q <= WTSR_ARMED;
            total_q <= 32'h00000000;
            addr_q <= 32'h00000000;
            seg_done_cnt_q <= 32'h00000000;
          end
        WTSR_ARMED:
          if (stop_cmd)
            state_q <= WTSR_DONE;
          else if (trig)
          begin
            state_q <= WTSR_RECORD;
            seg_cnt_q <= 32'h00000000;
          end
        WTSR_RECORD:
        begin
          seg_cnt_q <= seg_cnt_q + 32'h00000001;
          total_q <= total_q + 32'h00000001;
          addr_q <= addr_q + 32'h00000001;
          if (stop_cmd)
            state_q <= WTSR_DONE;
          else if (seg_last)
          begin
            seg_done_cnt_q <= seg_done_cnt_q + 32'h00000001;
            if (!seg_mode)
              state_q <= WTSR_DONE;
            else if (!fifo_q && total_last)
              state_q <= WTSR_DONE;
            else
              state_q <= WTSR_ARMED;
          end
        end
        default: state_q <= WTSR_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_mem <= '0;
      o_trig <= 1'b0;
      o_seg_done <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      o_mem.valid <= (state_q == WTSR_RECORD) && !stop_cmd;
      o_mem.addr <= addr_q;
      o_mem.data <= i_sample;
      o_trig <= (state_q == WTSR_ARMED) && trig && !stop_cmd;
      o_seg_done <= (state_q == WTSR_RECORD) && !stop_cmd && seg_last;
      o_busy <= (state_q == WTSR_ARMED) || (state_q == WTSR_RECORD);
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // timed at a four-sample length: exit, then three more outside samples
  property p_long_out_expiry;
    (ch_mode_q == `WTSR_MODE_LONG_OUTSIDE) && src_ok && (pulse_len == 8'h04) && exit_win
      ##1 ((ch_mode_q == `WTSR_MODE_LONG_OUTSIDE) && !in_win)[*3] |-> trig;
  endproperty
  a_long_out_expiry: assert property (p_long_out_expiry)
    else $error("long outside expiry did not trigger");

  property p_long_out_cancel;
    (ch_mode_q == `WTSR_MODE_LONG_OUTSIDE) && run_q && entry && !expire
      ##1 (ch_mode_q == `WTSR_MODE_LONG_OUTSIDE) |-> !run_q;
  endproperty
  a_long_out_cancel: assert property (p_long_out_cancel)
    else $error("re-entry did not cancel counter");

  // expiry must drop the counter so a later exit cannot trigger
  property p_short_in_no_expiry;
    (ch_mode_q == `WTSR_MODE_SHORT_INSIDE) && expire && in_win
      ##1 (ch_mode_q == `WTSR_MODE_SHORT_INSIDE) |-> !run_q && !trig;
  endproperty
  a_short_in_no_expiry: assert property (p_short_in_no_expiry)
    else $error("short inside triggered on expiry");

  property p_short_out_no_expiry;
    (ch_mode_q == `WTSR_MODE_SHORT_OUTSIDE) && expire && !in_win
      ##1 (ch_mode_q == `WTSR_MODE_SHORT_OUTSIDE) |-> !run_q && !trig;
  endproperty
  a_short_out_no_expiry: assert property (p_short_out_no_expiry)
    else $error("short outside triggered on expiry");

  property p_counter_range;
    run_q |-> (cnt_q >= 8'h01) && (cnt_q < `WTSR_PULSE_MAX);
  endproperty
  a_counter_range: assert property (p_counter_range)
    else $error("pulse counter out of range");

  property p_rearm;
    (state_q == WTSR_RECORD) && seg_last && seg_mode && fifo_q && !stop_cmd
      |=> (state_q == WTSR_ARMED);
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("no rearm after segment");

  property p_seg_len;
    (state_q == WTSR_RECORD) |-> (seg_cnt_q < rec_len) || (rec_len == 32'h00000000);
  endproperty
  a_seg_len: assert property (p_seg_len)
    else $error("segment overran its length");

  property p_total_stop;
    (state_q == WTSR_RECORD) && seg_last && seg_mode && !fifo_q && total_last
      && !stop_cmd |=> (state_q == WTSR_DONE) ##1 !o_mem.valid;
  endproperty
  a_total_stop: assert property (p_total_stop)
    else $error("standard mode did not stop at total");

  property p_trig_starts_record;
    (state_q == WTSR_ARMED) && trig && !stop_cmd
      |=> (state_q == WTSR_RECORD) ##1 (o_mem.valid || $past(stop_cmd));
  endproperty
  a_trig_starts_record: assert property (p_trig_starts_record)
    else $error("trigger did not start a segment");

  c_long_out: cover property ((ch_mode_q == `WTSR_MODE_LONG_OUTSIDE) && trig);
  c_short_in: cover property ((ch_mode_q == `WTSR_MODE_SHORT_INSIDE) && trig);
  c_two_segs: cover property (o_seg_done ##[1:300] o_seg_done);
  c_fifo_stop: cover property (fifo_q && stop_cmd && (state_q == WTSR_RECORD));

endmodule : wtsr_top
`default_nettype wire

// ===== wtsr_consts.svh
// register offsets, codes and field positions of the window trigger recorder
`ifndef WTSR_CONSTS_SVH
`define WTSR_CONSTS_SVH

// register byte addresses
`define WTSR_ADDR_TOTAL_COUNT 18'h02710
`define WTSR_ADDR_SEG_LEN 18'h02774
`define WTSR_ADDR_TRIG_SRC 18'h09c40
`define WTSR_ADDR_CH_MODE 18'h09d08
`define WTSR_ADDR_UPPER 18'h0a410
`define WTSR_ADDR_LOWER 18'h0a474
`define WTSR_ADDR_PULSE_LEN 18'h0abe0
`define WTSR_ADDR_SEG_ENABLE 18'h35b60
`define WTSR_ADDR_CONTROL 18'h30000
`define WTSR_ADDR_STATUS 18'h30004
`define WTSR_ADDR_SEG_DONE_CNT 18'h30008

// trigger source and channel mode codes
`define WTSR_SRC_ANALOG_CHANNEL 32'h00004e48
`define WTSR_MODE_ENTER 32'h00002738
`define WTSR_MODE_LONG_INSIDE 32'h00002739
`define WTSR_MODE_SHORT_INSIDE 32'h0000273a
`define WTSR_MODE_LEAVE 32'h00002742
`define WTSR_MODE_LONG_OUTSIDE 32'h00002743
`define WTSR_MODE_SHORT_OUTSIDE 32'h00002744

// pulse qualifier limits in samples
`define WTSR_PULSE_MIN 8'h02
`define WTSR_PULSE_MAX 8'hff

// control register fields (writes act as one-cycle commands, bit 2 is stored)
`define WTSR_CTL_START 0
`define WTSR_CTL_STOP 1
`define WTSR_CTL_FIFO 2

// status register fields
`define WTSR_STS_ARMED 0
`define WTSR_STS_RECORD 1
`define WTSR_STS_DONE 2

// reset values
`define WTSR_RST_WORD 32'h00000000
`define WTSR_RST_PULSE 32'h00000002

`endif

// ===== wtsr_pkg.sv
// types shared by the window trigger segmented recorder
package wtsr_pkg;

  // acquisition sequencer states
  typedef enum logic [1:0] {
    WTSR_IDLE = 2'b00,
    WTSR_ARMED = 2'b01,
    WTSR_RECORD = 2'b10,
    WTSR_DONE = 2'b11
  } wtsr_state_t;

  // one sample written into acquisition memory
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [7:0] data;
  } wtsr_mem_wr_t;

  // register port request from software
  typedef struct packed {
    logic wr;
    logic rd;
    logic [17:0] addr;
    logic [31:0] wdata;
  } wtsr_reg_req_t;

endpackage : wtsr_pkg

// ===== wtsr_mem_model.sv
// host memory model: counts sample writes and segment ends and flags gaps in the address run
`timescale 1ns/1ps
`default_nettype none
module wtsr_mem_model
  import wtsr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_clr,
  input wire wtsr_mem_wr_t i_mem,
  input wire logic i_seg_done,
  output var int o_writes,
  output var int o_segs,
  output logic [7:0] o_first,
  output logic o_gap
);
  // ==========
  // block drain
  // a gap in the address run means a lost or doubled sample
  always @(posedge i_clk)
  begin
    if (i_clr)
    begin
      o_writes <= 0;
      o_segs <= 0;
      o_gap <= 1'b0;
      o_first <= 8'h00;
    end
    else
    begin
      if (i_mem.valid === 1'b1)
      begin
        if (o_writes == 0)
          o_first <= i_mem.data;
        if (i_mem.addr !== 32'(o_writes))
          o_gap <= 1'b1;
        o_writes <= o_writes + 1;
      end
      if (i_seg_done === 1'b1)
        o_segs <= o_segs + 1;
    end
  end
endmodule : wtsr_mem_model
`default_nettype wire

// ===== wtsr_top_tb_top.sv
// self-checking testbench of the window trigger segmented recorder
`timescale 1ns/1ps
`default_nettype none
`include "wtsr_consts.svh"
module wtsr_top_tb_top
  import wtsr_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  wtsr_reg_req_t i_req = '0;
  logic [7:0] i_sample = 8'h80;
  logic [31:0] o_rdata;
  wtsr_mem_wr_t o_mem;
  logic o_trig, o_seg_done, o_busy, clr;
  logic [7:0] first;
  logic gap;
  logic [31:0] rv;
  int writes, segs, t0;
  int trig_n = 0;
  int err_total = 0;
  int num_checks = 0;
  // ==========
  // harness
  always #12.5 i_clk = ~i_clk;
  wtsr_top u_wtsr_top (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_sample(i_sample),
    .o_rdata(o_rdata), .o_mem(o_mem), .o_trig(o_trig), .o_seg_done(o_seg_done),
    .o_busy(o_busy));
  wtsr_mem_model u_wtsr_mem_model (.i_clk(i_clk), .i_clr(clr), .i_mem(o_mem),
    .i_seg_done(o_seg_done), .o_writes(writes), .o_segs(segs), .o_first(first), .o_gap(gap));
  // trigger pulses are one cycle, so count them at every edge
  always @(posedge i_clk)
  begin
    if (o_trig === 1'b1)
      trig_n <= trig_n + 1;
  end
  // ==========
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask : chk
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    i_req <= '0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [17:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge i_clk);
    i_req <= '0;
    #1;
    d = o_rdata;
  endtask : rd
  // inside level 0x80, outside 0xf0 against a 0x40..0xc0 window
  task automatic play(input bit a, input int n1, input int n2, input int n3);
    repeat (n1) @(posedge i_clk) i_sample <= a ? 8'h80 : 8'hf0;
    repeat (n2) @(posedge i_clk) i_sample <= a ? 8'hf0 : 8'h80;
    repeat (n3) @(posedge i_clk) i_sample <= a ? 8'h80 : 8'hf0;
  endtask : play
  task automatic arm(input logic [31:0] mode, input logic [31:0] ctl, input bit a);
    @(posedge i_clk) i_sample <= a ? 8'h80 : 8'hf0;
    wr(`WTSR_ADDR_CH_MODE, mode);
    @(posedge i_clk) clr <= 1'b1;
    @(posedge i_clk) clr <= 1'b0;
    wr(`WTSR_ADDR_CONTROL, ctl);
    t0 = trig_n;
  endtask : arm
  // one row: expected trigger count after a level pattern
  task automatic row(input bit a, input int n1, input int n2, input int n3, input int e);
    t0 = trig_n;
    play(a, n1, n2, n3);
    repeat (2) @(posedge i_clk);
    chk("trigger count", 32'(trig_n - t0), 32'(e));
  endtask : row
  // ==========
  // scenarios
  task automatic t_regs;
    rd(`WTSR_ADDR_PULSE_LEN, rv);
    chk("pulse length reset", rv, 32'h2);
    rd(`WTSR_ADDR_SEG_ENABLE, rv);
    chk("enable reset", rv, 32'h0);
    rd(18'h3fffc, rv);
    chk("unmapped read", rv, 32'h0);
    wr(`WTSR_ADDR_TRIG_SRC, `WTSR_SRC_ANALOG_CHANNEL);
    wr(`WTSR_ADDR_UPPER, 32'hc0);
    wr(`WTSR_ADDR_LOWER, 32'h40);
    wr(`WTSR_ADDR_PULSE_LEN, 32'h4);
    wr(`WTSR_ADDR_SEG_ENABLE, 32'h1);
    wr(`WTSR_ADDR_SEG_LEN, 32'h3);
    rd(`WTSR_ADDR_SEG_LEN, rv);
    chk("segment length", rv, 32'h3);
  endtask : t_regs
  task automatic t_long_outside;
    arm(`WTSR_MODE_LONG_OUTSIDE, 32'h5, 1'b1);
    row(1'b1, 3, 8, 6, 1);
    row(1'b1, 3, 2, 8, 0);
    wr(`WTSR_ADDR_CONTROL, 32'h2);
  endtask : t_long_outside
  task automatic t_short_inside;
    arm(`WTSR_MODE_SHORT_INSIDE, 32'h5, 1'b0);
    row(1'b0, 3, 2, 6, 1);
    row(1'b0, 3, 8, 4, 0);
    wr(`WTSR_ADDR_CONTROL, 32'h2);
  endtask : t_short_inside
  task automatic t_short_outside;
    arm(`WTSR_MODE_SHORT_OUTSIDE, 32'h5, 1'b1);
    row(1'b1, 3, 2, 6, 1);
    row(1'b1, 3, 8, 4, 0);
    wr(`WTSR_ADDR_CONTROL, 32'h2);
  endtask : t_short_outside
  // plain enter and leave, long inside, and a foreign trigger source
  task automatic t_plain;
    arm(`WTSR_MODE_ENTER, 32'h5, 1'b0);
    row(1'b0, 3, 2, 6, 1);
    wr(`WTSR_ADDR_TRIG_SRC, 32'h0);
    row(1'b0, 3, 2, 6, 0);
    wr(`WTSR_ADDR_TRIG_SRC, `WTSR_SRC_ANALOG_CHANNEL);
    wr(`WTSR_ADDR_CONTROL, 32'h2);
    arm(`WTSR_MODE_LEAVE, 32'h5, 1'b1);
    row(1'b1, 3, 2, 6, 1);
    wr(`WTSR_ADDR_CONTROL, 32'h2);
    arm(`WTSR_MODE_LONG_INSIDE, 32'h5, 1'b0);
    row(1'b0, 3, 8, 4, 1);
    row(1'b0, 3, 2, 6, 0);
    wr(`WTSR_ADDR_CONTROL, 32'h2);
  endtask : t_plain
  // recording: pulses of two outside samples, trigger on each re-entry
  task automatic t_rec(input logic [31:0] en, input logic [31:0] ctl, input logic [31:0] sl,
    input logic [31:0] tot, input int np, input int ew, input int es, input logic eb);
    wr(`WTSR_ADDR_SEG_ENABLE, en);
    wr(`WTSR_ADDR_SEG_LEN, sl);
    wr(`WTSR_ADDR_TOTAL_COUNT, tot);
    arm(`WTSR_MODE_SHORT_OUTSIDE, ctl, 1'b1);
    repeat (np) play(1'b0, 2, 6, 0);
    repeat (4) @(posedge i_clk);
    chk("samples written", 32'(writes), 32'(ew));
    chk("segments", 32'(segs), 32'(es));
    chk("first sample", {24'h0, first}, 32'h80);
    chk("address gap", {31'h0, gap}, 32'h0);
    chk("busy", {31'h0, o_busy}, {31'h0, eb});
  endtask : t_rec
  task automatic t_standard;
    t_rec(32'h1, 32'h1, 32'h3, 32'h6, 3, 6, 2, 1'b0);
    rd(`WTSR_ADDR_STATUS, rv);
    chk("status done", rv, 32'h4);
    rd(`WTSR_ADDR_SEG_DONE_CNT, rv);
    chk("segment count", rv, 32'h2);
  endtask : t_standard
  task automatic t_single;
    t_rec(32'h0, 32'h1, 32'h3, 32'h5, 2, 5, 1, 1'b0);
  endtask : t_single
  task automatic t_fifo;
    t_rec(32'h1, 32'h5, 32'h2, 32'h2, 3, 6, 3, 1'b1);
    wr(`WTSR_ADDR_CONTROL, 32'h2);
    repeat (2) @(posedge i_clk);
    chk("busy after stop", {31'h0, o_busy}, 32'h0);
  endtask : t_fifo
  // ==========
  // verdict
  task automatic stop_test;
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // the run needs well under 2000 cycles
  initial
  begin
    #200000;
    err_total++;
    stop_test();
  end
  initial
  begin
    clr = 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    clr <= 1'b0;
    t_regs();
    t_long_outside();
    t_short_inside();
    t_short_outside();
    t_plain();
    t_standard();
    t_single();
    t_fifo();
    stop_test();
  end
endmodule : wtsr_top_tb_top
`default_nettype wire
